// ==== common/aimg_pkg.sv ====
// Purpose: Shared constants and carriers for the record gain and input mix register bank
// Assumes: 8-bit register port, one clock
// Notes: Level codes above the last attenuation step and below the disconnect code are reserved
package aimg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LVL_W = 4;
  localparam int GAIN_W = 7;
  localparam int NUM_ROUTES = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_RIGHT_RECORD_GAIN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MIC_PAIR_TO_LEFT_MIX = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_MIC_PAIR_TO_RIGHT_MIX = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_LINE_IN_LEFT_TO_LEFT_MIX = 8'h13;

  // Field positions
  localparam int MUTE_BIT = 7;
  localparam int GAIN_MSB = 6;
  localparam int GAIN_LSB = 0;
  localparam int HI_LVL_MSB = 7;
  localparam int HI_LVL_LSB = 4;
  localparam int LO_LVL_MSB = 3;
  localparam int LO_LVL_LSB = 0;
  localparam int DIFF_BIT = 7;
  localparam int LINE_LVL_MSB = 6;
  localparam int LINE_LVL_LSB = 3;

  // Field values
  localparam logic [GAIN_W-1:0] GAIN_MAX = 7'h77;
  localparam logic [LVL_W-1:0] LVL_MAX_ATTEN = 4'h8;
  localparam logic [LVL_W-1:0] LVL_DISCONNECT = 4'hF;

  // Reset values and line input write mask
  localparam logic [DATA_W-1:0] RST_RIGHT_RECORD_GAIN = 8'h80;
  localparam logic [DATA_W-1:0] RST_MIC_PAIR = 8'hFF;
  localparam logic [DATA_W-1:0] RST_LINE_IN = 8'h78;
  localparam logic [DATA_W-1:0] LINE_IN_USED_MASK = 8'hF8;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // Route indices
  localparam int RT_MIC_L_TO_L = 0;
  localparam int RT_MIC_R_TO_L = 1;
  localparam int RT_MIC_L_TO_R = 2;
  localparam int RT_MIC_R_TO_R = 3;
  localparam int RT_LINE_L_TO_L = 4;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } aimg_wr_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
  } aimg_rd_t;

  typedef struct packed {
    logic connect;
    logic [LVL_W-1:0] level;
  } aimg_route_t;
endpackage : aimg_pkg

// ==== logic/aimg_regs.sv ====
// Purpose: Right record amplifier mute/gain and analog input mix routing registers
// Assumes: Register port synchronous to clk; one write and one read strobe per cycle
// Notes: Routing and gain outputs decode the stored fields; reads answer one cycle later
//
// Contract
// - Right amplifier mute at bit 7, resets to 1; writing 0 un-mutes.
// - Right gain field bits 6..0, resets to zero, 0.5 dB per code step.
// - Right gain saturates at code 1110111; higher codes give the same gain.
// - Level fields attenuate 1.5 dB per step, code 0000 to code 1000.
// - Level code 1111, the reset value, disconnects the input from its mixer.
// - Valid code at bits 7..4 of left mix register connects left mic.
// - Valid code at bits 3..0 of left mix register connects right mic.
// - Bits 7..4 of right mix register route left mic to right mixer.
// - Bits 3..0 of right mix register route right mic to right mixer.
// - Line input register bit 7 selects differential; reset 0 is single-ended.
// - Line input level field at bits 6..3, resets to 1111, same encoding.
`timescale 1ns/1ps
module aimg_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire aimg_pkg::aimg_wr_t reg_wr,
  input wire aimg_pkg::aimg_rd_t reg_rd,
  output logic [aimg_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Record amplifier controls
  output logic right_pga_mute,
  output logic [aimg_pkg::GAIN_W-1:0] right_pga_gain,
  // Mixer routing
  output aimg_pkg::aimg_route_t [aimg_pkg::NUM_ROUTES-1:0] route,
  output logic first_line_left_input_diff
);
  import aimg_pkg::*;

  logic [DATA_W-1:0] right_record_gain, next_right_record_gain;
  logic [DATA_W-1:0] mic_pair_to_left_mix, next_mic_pair_to_left_mix;
  logic [DATA_W-1:0] mic_pair_to_right_mix, next_mic_pair_to_right_mix;
  logic [DATA_W-1:0] line_in_left_to_left_mix, next_line_in_left_to_left_mix;
  logic [DATA_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic [LVL_W-1:0] lvl [NUM_ROUTES];

  // Register writes; unmapped addresses are ignored
  always_comb begin
    next_right_record_gain = right_record_gain;
    next_mic_pair_to_left_mix = mic_pair_to_left_mix;
    next_mic_pair_to_right_mix = mic_pair_to_right_mix;
    next_line_in_left_to_left_mix = line_in_left_to_left_mix;
    if (reg_wr.en) begin
      case (reg_wr.addr)
        OFS_RIGHT_RECORD_GAIN: next_right_record_gain = reg_wr.data;
        OFS_MIC_PAIR_TO_LEFT_MIX: next_mic_pair_to_left_mix = reg_wr.data;
        OFS_MIC_PAIR_TO_RIGHT_MIX: next_mic_pair_to_right_mix = reg_wr.data;
        // Low bits belong to other controls and are not kept here
        OFS_LINE_IN_LEFT_TO_LEFT_MIX: next_line_in_left_to_left_mix = reg_wr.data & LINE_IN_USED_MASK;
        default: next_right_record_gain = right_record_gain;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      right_record_gain <= RST_RIGHT_RECORD_GAIN;
      mic_pair_to_left_mix <= RST_MIC_PAIR;
      mic_pair_to_right_mix <= RST_MIC_PAIR;
      line_in_left_to_left_mix <= RST_LINE_IN;
    end else begin
      right_record_gain <= next_right_record_gain;
      mic_pair_to_left_mix <= next_mic_pair_to_left_mix;
      mic_pair_to_right_mix <= next_mic_pair_to_right_mix;
      line_in_left_to_left_mix <= next_line_in_left_to_left_mix;
    end
  end

  // Register reads; a read in the same cycle as a write returns the old value
  always_comb begin
    next_rd_valid = reg_rd.en;
    next_rd_data = rd_data;
    if (reg_rd.en) begin
      case (reg_rd.addr)
        OFS_RIGHT_RECORD_GAIN: next_rd_data = right_record_gain;
        OFS_MIC_PAIR_TO_LEFT_MIX: next_rd_data = mic_pair_to_left_mix;
        OFS_MIC_PAIR_TO_RIGHT_MIX: next_rd_data = mic_pair_to_right_mix;
        OFS_LINE_IN_LEFT_TO_LEFT_MIX: next_rd_data = line_in_left_to_left_mix;
        default: next_rd_data = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= READ_UNMAPPED;
      rd_valid <= 1'h0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // Amplifier controls and line input mode
  assign right_pga_mute = right_record_gain[MUTE_BIT];
  // Codes past the top step are clamped so the analog side never sees them
  assign right_pga_gain = (right_record_gain[GAIN_MSB:GAIN_LSB] > GAIN_MAX) ? GAIN_MAX
                          : right_record_gain[GAIN_MSB:GAIN_LSB];
  assign first_line_left_input_diff = line_in_left_to_left_mix[DIFF_BIT];

  // Level field selection per route
  assign lvl[RT_MIC_L_TO_L] = mic_pair_to_left_mix[HI_LVL_MSB:HI_LVL_LSB];
  assign lvl[RT_MIC_R_TO_L] = mic_pair_to_left_mix[LO_LVL_MSB:LO_LVL_LSB];
  assign lvl[RT_MIC_L_TO_R] = mic_pair_to_right_mix[HI_LVL_MSB:HI_LVL_LSB];
  assign lvl[RT_MIC_R_TO_R] = mic_pair_to_right_mix[LO_LVL_MSB:LO_LVL_LSB];
  assign lvl[RT_LINE_L_TO_L] = line_in_left_to_left_mix[LINE_LVL_MSB:LINE_LVL_LSB];

  // Reserved codes keep the input disconnected, a safe answer to a misprogram
  for (genvar g = 0; g < NUM_ROUTES; g++) begin : g_route
    always_comb begin
      route[g].connect = (lvl[g] <= LVL_MAX_ATTEN);
      route[g].level = route[g].connect ? lvl[g] : LVL_DISCONNECT;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_mute_follows_write: assert property (
    reg_wr.en && reg_wr.addr == OFS_RIGHT_RECORD_GAIN |=> right_pga_mute == $past(reg_wr.data[MUTE_BIT]))
    else $error("Right mute did not follow write");

  a_gain_linear_range: assert property (
    right_record_gain[GAIN_MSB:GAIN_LSB] <= GAIN_MAX |-> right_pga_gain == right_record_gain[GAIN_MSB:GAIN_LSB])
    else $error("Right gain not equal to field in linear range");

  a_gain_saturates: assert property (
    reg_wr.en && reg_wr.addr == OFS_RIGHT_RECORD_GAIN && reg_wr.data[GAIN_MSB:GAIN_LSB] > GAIN_MAX
    |=> right_pga_gain == GAIN_MAX)
    else $error("Right gain did not saturate");

  a_level_attenuation: assert property (
    route[RT_MIC_R_TO_R].connect |-> route[RT_MIC_R_TO_R].level <= LVL_MAX_ATTEN)
    else $error("Connected route carries invalid level");

  a_disconnect_code: assert property (
    lvl[RT_MIC_L_TO_R] == LVL_DISCONNECT |-> !route[RT_MIC_L_TO_R].connect)
    else $error("Disconnect code left input connected");

  a_mic_left_to_left: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_LEFT_MIX && reg_wr.data[HI_LVL_MSB:HI_LVL_LSB] <= LVL_MAX_ATTEN
    |=> route[RT_MIC_L_TO_L].connect && route[RT_MIC_L_TO_L].level == $past(reg_wr.data[HI_LVL_MSB:HI_LVL_LSB]))
    else $error("Left mic not connected to left mixer");

  a_mic_right_to_left: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_LEFT_MIX
    |=> route[RT_MIC_R_TO_L].connect == ($past(reg_wr.data[LO_LVL_MSB:LO_LVL_LSB]) <= LVL_MAX_ATTEN))
    else $error("Right mic to left mixer connect wrong");

  a_mic_left_to_right: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_RIGHT_MIX && reg_wr.data[HI_LVL_MSB:HI_LVL_LSB] <= LVL_MAX_ATTEN
    |=> route[RT_MIC_L_TO_R].connect ##1 route[RT_MIC_L_TO_R].connect || $past(reg_wr.en))
    else $error("Left mic not connected to right mixer");

  a_mic_right_to_right: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_RIGHT_MIX
    |=> route[RT_MIC_R_TO_R].level == (($past(reg_wr.data[LO_LVL_MSB:LO_LVL_LSB]) <= LVL_MAX_ATTEN)
        ? $past(reg_wr.data[LO_LVL_MSB:LO_LVL_LSB]) : LVL_DISCONNECT))
    else $error("Right mic to right mixer level wrong");

  a_line_diff_mode: assert property (
    reg_wr.en && reg_wr.addr == OFS_LINE_IN_LEFT_TO_LEFT_MIX
    |=> first_line_left_input_diff == $past(reg_wr.data[DIFF_BIT]))
    else $error("Line input configuration not updated");

  a_line_level_field: assert property (
    reg_wr.en && reg_wr.addr == OFS_LINE_IN_LEFT_TO_LEFT_MIX
    |=> route[RT_LINE_L_TO_L].connect == ($past(reg_wr.data[LINE_LVL_MSB:LINE_LVL_LSB]) <= LVL_MAX_ATTEN))
    else $error("Line input level connect wrong");

  a_read_stable: assert property (
    !reg_wr.en && !$past(reg_wr.en) && reg_rd.en && reg_rd.addr == OFS_RIGHT_RECORD_GAIN
    |=> rd_valid && rd_data == right_record_gain)
    else $error("Read data does not match gain register");

  a_mute_unmute_write: assert property (
    reg_wr.en && reg_wr.addr == OFS_RIGHT_RECORD_GAIN && !reg_wr.data[MUTE_BIT]
    |=> !right_pga_mute)
    else $error("Right mute stayed set after clearing write");

  a_mute_holds: assert property (
    !(reg_wr.en && reg_wr.addr == OFS_RIGHT_RECORD_GAIN)
    |=> $stable(right_pga_mute))
    else $error("Right mute changed without a write");

  a_gain_write_value: assert property (
    reg_wr.en && reg_wr.addr == OFS_RIGHT_RECORD_GAIN && reg_wr.data[GAIN_MSB:GAIN_LSB] <= GAIN_MAX
    |=> right_pga_gain == $past(reg_wr.data[GAIN_MSB:GAIN_LSB]))
    else $error("Right gain did not take written code");

  a_gain_holds: assert property (
    !(reg_wr.en && reg_wr.addr == OFS_RIGHT_RECORD_GAIN)
    |=> $stable(right_pga_gain))
    else $error("Right gain changed without a write");

  a_gain_top_clamp: assert property (
    right_pga_gain <= GAIN_MAX)
    else $error("Right gain above top step");

  a_reserved_left_mic: assert property (
    lvl[RT_MIC_L_TO_L] > LVL_MAX_ATTEN
    |-> !route[RT_MIC_L_TO_L].connect && route[RT_MIC_L_TO_L].level == LVL_DISCONNECT)
    else $error("Left mic to left mixer not disconnected");

  a_reserved_right_mic: assert property (
    lvl[RT_MIC_R_TO_R] > LVL_MAX_ATTEN
    |-> !route[RT_MIC_R_TO_R].connect && route[RT_MIC_R_TO_R].level == LVL_DISCONNECT)
    else $error("Right mic to right mixer not disconnected");

  a_left_mic_cut: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_LEFT_MIX && reg_wr.data[HI_LVL_MSB:HI_LVL_LSB] == LVL_DISCONNECT
    |=> !route[RT_MIC_L_TO_L].connect)
    else $error("Left mic stayed on left mixer after disconnect");

  a_left_mix_holds: assert property (
    !(reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_LEFT_MIX)
    |=> $stable(route[RT_MIC_L_TO_L]) && $stable(route[RT_MIC_R_TO_L]))
    else $error("Left mixer routing changed without a write");

  a_right_to_left_level: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_LEFT_MIX && reg_wr.data[LO_LVL_MSB:LO_LVL_LSB] <= LVL_MAX_ATTEN
    |=> route[RT_MIC_R_TO_L].level == $past(reg_wr.data[LO_LVL_MSB:LO_LVL_LSB]))
    else $error("Right mic to left mixer level wrong");

  a_left_to_right_conn: assert property (
    reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_RIGHT_MIX
    |=> route[RT_MIC_L_TO_R].connect == ($past(reg_wr.data[HI_LVL_MSB:HI_LVL_LSB]) <= LVL_MAX_ATTEN))
    else $error("Left mic to right mixer connect wrong");

  a_right_mix_holds: assert property (
    !(reg_wr.en && reg_wr.addr == OFS_MIC_PAIR_TO_RIGHT_MIX)
    |=> $stable(route[RT_MIC_L_TO_R]) && $stable(route[RT_MIC_R_TO_R]))
    else $error("Right mixer routing changed without a write");

  a_line_holds: assert property (
    !(reg_wr.en && reg_wr.addr == OFS_LINE_IN_LEFT_TO_LEFT_MIX)
    |=> $stable(route[RT_LINE_L_TO_L]) && $stable(first_line_left_input_diff))
    else $error("Line input routing changed without a write");

  a_line_level_value: assert property (
    route[RT_LINE_L_TO_L].connect
    |-> route[RT_LINE_L_TO_L].level == lvl[RT_LINE_L_TO_L])
    else $error("Line input level differs from stored code");

  a_line_reserved: assert property (
    lvl[RT_LINE_L_TO_L] > LVL_MAX_ATTEN
    |-> !route[RT_LINE_L_TO_L].connect && route[RT_LINE_L_TO_L].level == LVL_DISCONNECT)
    else $error("Line input not disconnected");

  a_line_low_bits: assert property (
    (line_in_left_to_left_mix & ~LINE_IN_USED_MASK) == READ_UNMAPPED)
    else $error("Line register kept bits it does not own");

  a_rd_valid_pulse: assert property (
    reg_rd.en |=> rd_valid)
    else $error("Read not answered");

  a_rd_valid_idle: assert property (
    !reg_rd.en |=> !rd_valid)
    else $error("Read answer without a read");

  a_rd_data_holds: assert property (
    !reg_rd.en |=> $stable(rd_data))
    else $error("Read data changed without a read");

  a_rd_left_mix: assert property (
    !reg_wr.en && reg_rd.en && reg_rd.addr == OFS_MIC_PAIR_TO_LEFT_MIX
    |=> rd_data == mic_pair_to_left_mix)
    else $error("Read data does not match left mix register");

  a_rd_right_mix: assert property (
    !reg_wr.en && reg_rd.en && reg_rd.addr == OFS_MIC_PAIR_TO_RIGHT_MIX
    |=> rd_data == mic_pair_to_right_mix)
    else $error("Read data does not match right mix register");

  a_rd_line: assert property (
    !reg_wr.en && reg_rd.en && reg_rd.addr == OFS_LINE_IN_LEFT_TO_LEFT_MIX
    |=> rd_data == line_in_left_to_left_mix)
    else $error("Read data does not match line register");

  a_rd_unmapped: assert property (
    reg_rd.en && reg_rd.addr != OFS_RIGHT_RECORD_GAIN && reg_rd.addr != OFS_MIC_PAIR_TO_LEFT_MIX
    && reg_rd.addr != OFS_MIC_PAIR_TO_RIGHT_MIX && reg_rd.addr != OFS_LINE_IN_LEFT_TO_LEFT_MIX
    |=> rd_data == READ_UNMAPPED)
    else $error("Unmapped read returned data");

  a_wr_unmapped: assert property (
    reg_wr.en && reg_wr.addr != OFS_RIGHT_RECORD_GAIN && reg_wr.addr != OFS_MIC_PAIR_TO_LEFT_MIX
    && reg_wr.addr != OFS_MIC_PAIR_TO_RIGHT_MIX && reg_wr.addr != OFS_LINE_IN_LEFT_TO_LEFT_MIX
    |=> $stable(right_record_gain) && $stable(mic_pair_to_left_mix) && $stable(mic_pair_to_right_mix)
        && $stable(line_in_left_to_left_mix))
    else $error("Unmapped write changed a register");

  // Reserved level codes are never driven by the bench; gain codes past the top step are, so the clamp is covered
  c_diff_set: cover property ($rose(first_line_left_input_diff));
  c_unmute: cover property ($fell(right_pga_mute));
  c_gain_clamped: cover property (right_record_gain[GAIN_MSB:GAIN_LSB] > GAIN_MAX);
  c_line_connect: cover property ($rose(route[RT_LINE_L_TO_L].connect));
  c_read_back: cover property (reg_wr.en ##1 reg_rd.en ##1 rd_valid);
endmodule : aimg_regs

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the record gain and input mix register bank
// Assumes: Inputs driven 1 ns after the rising edge; reads answer one cycle later
// Notes: Only valid level codes are written; reserved codes are left to software rules
`timescale 1ns/1ps
module testbench;
  import aimg_pkg::*;
  logic clk;
  logic rst_n;
  aimg_wr_t reg_wr;
  aimg_rd_t reg_rd;
  logic [DATA_W-1:0] rd_data;
  logic rd_valid;
  logic right_pga_mute;
  logic [GAIN_W-1:0] right_pga_gain;
  aimg_route_t [NUM_ROUTES-1:0] route;
  logic first_line_left_input_diff;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  aimg_regs dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_data(rd_data),
    .rd_valid(rd_valid), .right_pga_mute(right_pga_mute), .right_pga_gain(right_pga_gain),
    .route(route), .first_line_left_input_diff(first_line_left_input_diff));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs well under 600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Idle cycle after each access so the strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = '{1'b1, a, d};
    @(posedge clk);
    #1 reg_wr.en = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd = '{1'b1, a};
    @(posedge clk);
    #1 reg_rd.en = 1'b0;
    chk("rd_valid", {7'h0, rd_valid}, 8'h01);
    chk("rd_data", rd_data, exp);
    @(posedge clk);
    #1 chk("rd_valid low", {7'h0, rd_valid}, 8'h00);
  endtask : rd

  // Codes 0..8 then disconnect; reserved codes never written
  function automatic logic [3:0] code_of(input int i);
    return (i == 9) ? LVL_DISCONNECT : 4'(i);
  endfunction : code_of

  task automatic chk_route(input int idx, input logic [3:0] c);
    logic conn;
    conn = (c <= LVL_MAX_ATTEN);
    chk($sformatf("route%0d", idx), {3'h0, route[idx]}, {3'h0, conn, conn ? c : LVL_DISCONNECT});
  endtask : chk_route

  task automatic test_reset();
    chk("mute", {7'h0, right_pga_mute}, 8'h01);
    chk("gain", {1'b0, right_pga_gain}, 8'h00);
    for (int i = 0; i < NUM_ROUTES; i++) chk_route(i, LVL_DISCONNECT);
    chk("diff", {7'h0, first_line_left_input_diff}, 8'h00);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    rd(OFS_RIGHT_RECORD_GAIN, 8'h80);
    rd(OFS_MIC_PAIR_TO_LEFT_MIX, 8'hFF);
    rd(OFS_MIC_PAIR_TO_RIGHT_MIX, 8'hFF);
    rd(OFS_LINE_IN_LEFT_TO_LEFT_MIX, 8'h78);
    $display("test reset done");
  endtask : test_reset

  task automatic test_gain();
    logic [7:0] gd [4] = '{8'h05, 8'h77, 8'h78, 8'hFF};
    logic [6:0] ge [4] = '{7'h05, 7'h77, 7'h77, 7'h77};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_RIGHT_RECORD_GAIN, gd[i]);
      chk("mute", {7'h0, right_pga_mute}, {7'h0, gd[i][7]});
      chk("gain", {1'b0, right_pga_gain}, {1'b0, ge[i]});
      rd(OFS_RIGHT_RECORD_GAIN, gd[i]);
    end
    $display("test gain done");
  endtask : test_gain

  task automatic test_mics();
    logic [3:0] a;
    logic [3:0] b;
    for (int i = 0; i < 10; i++) begin
      a = code_of(i);
      b = code_of(9 - i);
      wr(OFS_MIC_PAIR_TO_LEFT_MIX, {a, b});
      wr(OFS_MIC_PAIR_TO_RIGHT_MIX, {b, a});
      chk_route(RT_MIC_L_TO_L, a);
      chk_route(RT_MIC_R_TO_L, b);
      chk_route(RT_MIC_L_TO_R, b);
      chk_route(RT_MIC_R_TO_R, a);
      rd(OFS_MIC_PAIR_TO_LEFT_MIX, {a, b});
      rd(OFS_MIC_PAIR_TO_RIGHT_MIX, {b, a});
    end
    $display("test mics done");
  endtask : test_mics

  task automatic test_line();
    logic [3:0] c;
    logic d;
    for (int i = 0; i < 10; i++) begin
      c = code_of(i);
      d = i[0];
      wr(OFS_LINE_IN_LEFT_TO_LEFT_MIX, {d, c, 3'h7});
      chk_route(RT_LINE_L_TO_L, c);
      chk("diff", {7'h0, first_line_left_input_diff}, {7'h0, d});
      rd(OFS_LINE_IN_LEFT_TO_LEFT_MIX, {d, c, 3'h0});
    end
    $display("test line done");
  endtask : test_line

  initial begin
    rst_n = 1'b0;
    reg_wr = '0;
    reg_rd = '0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    test_reset();
    test_gain();
    test_mics();
    test_line();
    tally_and_finish();
  end
endmodule : testbench
